//--- hpp_pkg.sv
// Package of constants and carriers for the dual-mode host port handshake.
//
// Notes on behaviour
// RULE1: Mode low selects separate read/write strobes.
// RULE2: Mode high selects data strobe style.
// RULE3: Control lines sampled on rising clock edges.
// RULE4: Write ready rises 4 to 9 clocks later.
// RULE5: Read ready rises 8 to 13 clocks later.
// RULE6: Strobe-mode write acknowledged 4 to 9 clocks.
// RULE7: Strobe-mode read acknowledged 8 to 13 clocks.
// RULE8: Host holds write strobe until ready.
// RULE9: Host holds address and data until ready.
// RULE10: Host holds data strobe until acknowledge.
package hpp_pkg;

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------

  // Clock period in nanoseconds.
  localparam int ClkPeriodNs = 50;
  // Typical write access in clock periods.
  localparam int WrAccCycles = 5;
  // Typical read access in clock periods.
  localparam int RdAccCycles = 10;
  // Documented bounds, kept for the checks.
  localparam int WrAccMin = 4;
  localparam int WrAccMax = 9;
  localparam int RdAccMin = 8;
  localparam int RdAccMax = 13;
  // Width of the access counter.
  localparam int CntW = 4;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------

  // Host control lines as they arrive at the pins.
  typedef struct packed {
    logic chipSelN;
    logic rdStrobeN;  // Read strobe, or data strobe in strobe mode.
    logic wrStrobeN;  // Write strobe, or read/write select.
  } hpp_ctrl_t;

  // Access requested towards the core.
  typedef struct packed {
    logic isRead;
    logic active;
  } hpp_acc_t;

endpackage : hpp_pkg

//--- hpp_sync.sv
// Two-flop synchroniser for a bundle of asynchronous pin levels.
`timescale 1ns/10ps
module hpp_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RstVal = '1
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Asynchronous level in, synchronised level out.
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);

  // A bundle needs at least one bit.
  if (W < 1) begin : g_badWidth
    $error("hpp_sync: width must be at least one");
  end

  // First stage, read only by the second stage.
  logic [W-1:0] meta_reg;
  // Second stage.
  logic [W-1:0] sync_reg;

  // The first stage registers the pins, the second the first; nothing else looks at the first.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RstVal;
      sync_reg <= RstVal;
    end else begin
      meta_reg <= asyncIn;
      sync_reg <= meta_reg;
    end
  end

  assign syncOut = sync_reg;

endmodule : hpp_sync

//--- hpp_port.sv
// Host port handshake: mode select, strobe decode and access timing.
`timescale 1ns/10ps
module hpp_port
  import hpp_pkg::*;
#(
  parameter int WrCycles = hpp_pkg::WrAccCycles,
  parameter int RdCycles = hpp_pkg::RdAccCycles
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Static bus style select: low separate strobes, high data strobe.
  input wire logic modeSel,
  // Host control pins.
  input wire hpp_pkg::hpp_ctrl_t hostCtrl,
  // Separate-strobe completion line.
  output logic ready,
  // Data-strobe acknowledge, open drain style.
  output logic data_ack_n,
  output logic dataAckOe,
  // Access towards the core and its completion.
  output hpp_pkg::hpp_acc_t coreAcc,
  output logic coreDone
);

  import hpp_pkg::*;

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------

  // Access times must stay inside the documented window; the upper
  // limit keeps three cycles of the budget for synchronisation and the take.
  if (WrCycles < WrAccMin || WrCycles > WrAccMax - 3 ||
      RdCycles < RdAccMin || RdCycles > RdAccMax - 3) begin : g_badCycles
    $error("hpp_port: access cycles out of range");
  end

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------

  // Synchronised pins; two cycles of latency are budgeted below.
  hpp_ctrl_t ctrlSync;
  // Mode pin after synchronisation.
  logic modeSync;

  // RULE3 sample controls
  hpp_sync #(.W(3), .RstVal(3'h7)) u_ctrl_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .asyncIn(hostCtrl),
    .syncOut(ctrlSync)
  );

  hpp_sync #(.W(1), .RstVal(1'h0)) u_mode_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .asyncIn(modeSel),
    .syncOut(modeSync)
  );

  // ----------------------------------------------------------------
  // Strobe decode
  // ----------------------------------------------------------------

  // Access requested and its direction, per bus style.
  logic reqOn;
  logic reqRead;

  // Decode the strobes according to the selected style.
  always_comb begin
    if (!modeSync) begin
      // RULE1 separate strobes
      reqOn = !ctrlSync.chipSelN &&
              (!ctrlSync.rdStrobeN || !ctrlSync.wrStrobeN);
      reqRead = !ctrlSync.rdStrobeN;
    end else begin
      // RULE2 data strobe style
      reqOn = !ctrlSync.chipSelN && !ctrlSync.rdStrobeN;
      reqRead = ctrlSync.wrStrobeN;
    end
  end

  // ----------------------------------------------------------------
  // Access state machine
  // ----------------------------------------------------------------

  typedef enum logic [1:0] {HppIdle, HppWait, HppDone} hpp_state_t;

  // State, direction and counter.
  hpp_state_t state_reg, state_next;
  logic isRead_reg, isRead_next;
  logic [CntW-1:0] cnt_reg, cnt_next;

  // Counts of remaining cycles; three were spent in synchronisation and the take.
  localparam logic [CntW-1:0] WrLoad = CntW'(WrCycles - 3);
  localparam logic [CntW-1:0] RdLoad = CntW'(RdCycles - 3);

  // Next state: wait the access time, then hold done until release.
  always_comb begin
    state_next = state_reg;
    isRead_next = isRead_reg;
    cnt_next = cnt_reg;
    unique case (state_reg)
      HppIdle: begin
        if (reqOn) begin
          // RULE4 write time
          // RULE5 read time
          state_next = HppWait;
          isRead_next = reqRead;
          cnt_next = reqRead ? RdLoad : WrLoad;
        end
      end
      HppWait: begin
        // A strobe dropped early aborts without completion.
        if (!reqOn) begin
          state_next = HppIdle;
        end else if (cnt_reg == '0) begin
          state_next = HppDone;
        end else begin
          cnt_next = cnt_reg - CntW'(1);
        end
      end
      HppDone: begin
        // RULE8 host holds strobe
        // RULE10 host holds strobe
        if (!reqOn) begin
          state_next = HppIdle;
        end
      end
    endcase
  end

  // Register the state group.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= HppIdle;
      isRead_reg <= 1'h0;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      isRead_reg <= isRead_next;
      cnt_reg <= cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // Completion outputs
  // ----------------------------------------------------------------

  // Ready is low while an access is pending, high otherwise.
  logic ready_reg, ready_next;
  logic ack_reg, ack_next;

  // RULE6 acknowledge write
  // RULE7 acknowledge read
  always_comb begin
    ready_next = !(state_next == HppWait);
    ack_next = modeSync && (state_next == HppDone);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_reg <= 1'h1;
      ack_reg <= 1'h0;
    end else begin
      ready_reg <= ready_next;
      ack_reg <= ack_next;
    end
  end

  // RULE9 host holds data
  assign ready = ready_reg;
  assign data_ack_n = !ack_reg;
  assign dataAckOe = ack_reg;
  assign coreAcc = '{isRead: isRead_reg, active: state_reg != HppIdle};
  assign coreDone = state_reg == HppDone;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  sequence s_wrStart;
    !modeSync && state_reg == HppIdle && reqOn && !reqRead;
  endsequence

  sequence s_rdStart;
    !modeSync && state_reg == HppIdle && reqOn && reqRead;
  endsequence

  property p_wrTime;
    @(posedge sys_clk) disable iff (!rst_n)
    s_wrStart ##1 reqOn[*4] |=> ready;
  endproperty
  a_wrTime: assert property (p_wrTime) // RULE4
    else $error("write ready late");

  property p_rdTime;
    @(posedge sys_clk) disable iff (!rst_n)
    s_rdStart ##1 reqOn[*8] |=> ready;
  endproperty
  a_rdTime: assert property (p_rdTime) // RULE5
    else $error("read ready late");

  property p_wrLow;
    @(posedge sys_clk) disable iff (!rst_n)
    s_wrStart |=> !ready;
  endproperty
  a_wrLow: assert property (p_wrLow) // RULE1
    else $error("ready not dropped");

  // RULE4 not too soon
  property p_wrEarly;
    @(posedge sys_clk) disable iff (!rst_n)
    s_wrStart ##1 reqOn |=> !ready;
  endproperty
  a_wrEarly: assert property (p_wrEarly) // RULE4
    else $error("write ready early");

  // RULE5 not too soon
  property p_rdEarly;
    @(posedge sys_clk) disable iff (!rst_n)
    s_rdStart ##1 reqOn[*5] |=> !ready;
  endproperty
  a_rdEarly: assert property (p_rdEarly) // RULE5
    else $error("read ready early");

  sequence s_dsWrStart;
    modeSync && state_reg == HppIdle && reqOn && !reqRead;
  endsequence

  sequence s_dsRdStart;
    modeSync && state_reg == HppIdle && reqOn && reqRead;
  endsequence

  property p_ackWr;
    @(posedge sys_clk) disable iff (!rst_n)
    s_dsWrStart ##1 (reqOn && modeSync)[*4] |=> !data_ack_n;
  endproperty
  a_ackWr: assert property (p_ackWr) // RULE6
    else $error("write acknowledge late");

  property p_ackRd;
    @(posedge sys_clk) disable iff (!rst_n)
    s_dsRdStart ##1 (reqOn && modeSync)[*8] |=> !data_ack_n;
  endproperty
  a_ackRd: assert property (p_ackRd) // RULE7
    else $error("read acknowledge late");

  property p_ackEarly;
    @(posedge sys_clk) disable iff (!rst_n)
    (state_reg == HppIdle && reqOn) |=> data_ack_n [*2];
  endproperty
  a_ackEarly: assert property (p_ackEarly) // RULE2
    else $error("acknowledge early");

  property p_noAckMode0;
    @(posedge sys_clk) disable iff (!rst_n)
    $past(!modeSync) |-> data_ack_n;
  endproperty
  a_noAckMode0: assert property (p_noAckMode0) // RULE1
    else $error("acknowledge in separate mode");

  property p_release;
    @(posedge sys_clk) disable iff (!rst_n)
    (state_reg == HppDone && !reqOn) |=> ##1 (ready && data_ack_n);
  endproperty
  a_release: assert property (p_release) // RULE3
    else $error("completion not released");

endmodule : hpp_port

//--- hpp_host_model.sv
// Host processor model that drives the port's control pins.
`timescale 1ns/10ps
module hpp_host_model
  import hpp_pkg::*;
(
  // Clock and completion lines from the port.
  input wire logic sys_clk,
  input wire logic ready,
  input wire logic data_ack_n,
  input wire logic dataAckOe,
  // Pins driven by the host.
  output hpp_pkg::hpp_ctrl_t hostCtrl,
  output logic modeSel
);
  // The acknowledge wire is pulled up whenever the port lets go of it.
  logic ackWire;
  assign ackWire = dataAckOe ? data_ack_n : 1'h1;

  // Idle control pins are high, as their pull-ups leave them; the mode pin starts low.
  initial begin
    hostCtrl = 3'h7;
    modeSel = 1'h0;
  end

  // One access; lat is edges from the first edge that samples the pins to completion, -1 if none came.
  // An abortAt above zero releases the strobe early, at the falling edge after that edge.
  task automatic access(input logic mode, input logic rd, input logic cs,
                        input int abortAt, output int lat);
    logic sawLow;
    logic done;
    sawLow = 1'h0;
    lat = -1;
    @(negedge sys_clk);
    modeSel = mode;
    // Mode is held still several edges before a request.
    repeat (4) @(negedge sys_clk);
    hostCtrl.chipSelN = ~cs;
    hostCtrl.rdStrobeN = mode ? 1'h0 : ~rd;
    hostCtrl.wrStrobeN = rd;
    @(posedge sys_clk);
    for (int k = 1; k <= 20; k++) begin
      @(posedge sys_clk);
      #1;
      if (ready === 1'h0) begin
        sawLow = 1'h1;
      end
      done = mode ? (ackWire === 1'h0) : (sawLow && ready === 1'h1);
      if (done && lat < 0) begin
        lat = k;
      end
      if (lat >= 0 && abortAt == 0) begin
        @(negedge sys_clk);
        hostCtrl = 3'h7;
        break;
      end
      if (k == abortAt) begin
        @(negedge sys_clk);
        hostCtrl = 3'h7;
      end
    end
    // An access that got no answer lets go of its pins before returning.
    if (lat < 0) begin
      @(negedge sys_clk);
      hostCtrl = 3'h7;
    end
  endtask : access
endmodule : hpp_host_model

//--- tb.sv
// Self-checking testbench for the dual-mode host port handshake.
`timescale 1ns/10ps
module tb;
  import hpp_pkg::*;
  // ----------------------------------------------------------------
  // Signals and counters
  // ----------------------------------------------------------------
  logic sys_clk;
  logic rst_n;
  logic modeSel;
  hpp_ctrl_t hostCtrl;
  logic ready;
  logic data_ack_n;
  logic dataAckOe;
  hpp_acc_t coreAcc;
  logic coreDone;
  int n_errors;
  int comparisons;
  int cycles;
  int lat;

  // A 50 ns clock.
  always #(ClkPeriodNs / 2) sys_clk = ~sys_clk;

  hpp_port uut (.sys_clk(sys_clk), .rst_n(rst_n), .modeSel(modeSel),
    .hostCtrl(hostCtrl), .ready(ready), .data_ack_n(data_ack_n),
    .dataAckOe(dataAckOe), .coreAcc(coreAcc), .coreDone(coreDone));

  hpp_host_model host (.sys_clk(sys_clk), .ready(ready),
    .data_ack_n(data_ack_n), .dataAckOe(dataAckOe),
    .hostCtrl(hostCtrl), .modeSel(modeSel));

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] got,
                       input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic conclude();
    if (n_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  // A hang is cut short well beyond the roughly 180 cycles needed.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      conclude();
    end
  end

  // Lines must be back at idle a few edges after the host lets go.
  task automatic t_idle();
    repeat (4) @(posedge sys_clk);
    #1;
    check("ready idle", ready, 1'h1);
    check("ack idle", data_ack_n, 1'h1);
    check("oe idle", dataAckOe, 1'h0);
    check("done idle", coreDone, 1'h0);
    check("active idle", coreAcc.active, 1'h0);
  endtask : t_idle

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check("rst ready", ready, 1'h1);
    check("rst ack", data_ack_n, 1'h1);
    check("rst oe", dataAckOe, 1'h0);
    check("rst acc", coreAcc, 2'h0);
    check("rst done", coreDone, 1'h0);
  endtask : t_reset

  // Separate strobes, write then read back to back.
  // Completion still stands when the host has just let go of the strobe.
  task automatic t_strobe_mode();
    host.access(1'h0, 1'h0, 1'h1, 0, lat);
    check("wr ready lat", lat, WrAccCycles);
    check("wr done", coreDone, 1'h1);
    check("wr acc", coreAcc, 2'h1);
    host.access(1'h0, 1'h1, 1'h1, 0, lat);
    check("rd ready lat", lat, RdAccCycles);
    check("rd done", coreDone, 1'h1);
    check("rd acc", coreAcc, 2'h3);
    t_idle();
  endtask : t_strobe_mode

  // Data strobe, write then read.
  task automatic t_data_mode();
    host.access(1'h1, 1'h0, 1'h1, 0, lat);
    check("wr ack lat", lat, WrAccCycles);
    check("wr ack oe", dataAckOe, 1'h1);
    t_idle();
    host.access(1'h1, 1'h1, 1'h1, 0, lat);
    check("rd ack lat", lat, RdAccCycles);
    check("rd ack oe", dataAckOe, 1'h1);
    check("rd acc", coreAcc, 2'h3);
    t_idle();
  endtask : t_data_mode

  // Strobes without chip select, or dropped early, get no answer.
  task automatic t_refused();
    host.access(1'h1, 1'h1, 1'h0, 0, lat);
    check("no cs ack", lat, 32'hFFFFFFFF);
    host.access(1'h0, 1'h0, 1'h0, 0, lat);
    check("no cs ready", lat, 32'hFFFFFFFF);
    host.access(1'h1, 1'h1, 1'h1, 2, lat);
    check("abort ack", lat, 32'hFFFFFFFF);
    t_idle();
  endtask : t_refused

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'h0;
    rst_n = 1'h0;
    n_errors = 0;
    comparisons = 0;
    cycles = 0;
    repeat (4) @(negedge sys_clk);
    t_reset();
    rst_n = 1'h1;
    t_strobe_mode();
    t_data_mode();
    t_refused();
    t_strobe_mode();
    conclude();
  end
endmodule : tb
